// [design/dsts_slave.sv]
// Response byte FIFO
module dsts_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          rdy_q, rdy_d;
    logic          push, pop;

    assign push      = in_valid && rdy_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = rdy_q;
    assign out_valid = cnt_q != '0;
    assign out_data  = mem[rp_q];

    // Pointer and fill level
    always_comb begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        if (push) wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
        if (pop) rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
        cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        rdy_d = cnt_d != (AW + 1)'(D);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) mem[wp_q] <= in_data;
    end
endmodule : dsts_fifo

// Telegram slave: receive, check, answer
module dsts_slave #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire dsts_pkg::dsts_cfg_t cfg,
    input  wire logic              line_rx,
    output logic                   line_tx,
    output logic                   line_tx_en,
    output logic                   req_valid,
    output dsts_pkg::dsts_req_t    req,
    input  wire logic [7:0]        rsp_data,
    input  wire logic              rsp_valid,
    output logic                   rsp_ready,
    input  wire logic              rsp_fail,
    input  wire logic [15:0]       rsp_fault
);
    logic [7:0]  rbuf [256];
    logic [15:0] tk_q, tk_d, rc_q, rc_d, gp_q, gp_d, dl_q, dl_d, tc_q, tc_d;
    logic [3:0]  rn_q, rn_d, tn_q, tn_d;
    logic [9:0]  rs_q, rs_d, full;
    logic [10:0] tsh_q, tsh_d;
    logic        rb_q, rb_d, tb_q, tb_d, tx_q, tx_d, oe_q, oe_d, rv_q, rv_d;
    logic [7:0]  x_q, x_d, len_q, len_d, adr_q, adr_d, di_q, di_d, tx_x_q, tx_x_d, tbyte, di_tx;
    logic [8:0]  ti_q, ti_d;
    dsts_pkg::dsts_fs_t  f_q, f_d;
    dsts_pkg::dsts_ts_t  t_q, t_d;
    dsts_pkg::dsts_req_t req_q, req_d;
    logic        tick, char_v, char_ok, gap_to, acc, hit, bc, tx_load, data_ph, buf_we;
    logic [7:0]  fo_data;
    logic        fo_valid;

    // Address decode for both formats
    function automatic logic [1:0] addr_dec(input logic [7:0] a, input logic [6:0] node);
        logic b;
        b = 1'b0;
        if (a[dsts_pkg::ADR_FMT_BIT]) begin
            b = a[6:0] == '0;
            return {b || a[6:0] == node, b};
        end
        b = a[dsts_pkg::ADR_BC_BIT];
        return {b || (node[6:5] == 2'b00 && a[4:0] == node[4:0]), b};
    endfunction : addr_dec

    // Big-endian word from the receive buffer
    function automatic logic [15:0] word_at(input logic [7:0] ofs);
        return {rbuf[ofs], rbuf[ofs + 8'h01]};
    endfunction : word_at

    dsts_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (rsp_data),
        .in_valid  (rsp_valid),
        .in_ready  (rsp_ready),
        .out_data  (fo_data),
        .out_valid (fo_valid),
        .out_ready (tx_load && data_ph)
    );

    assign tick    = tk_q == '0;
    assign full    = {line_rx, rs_q[9:1]};
    assign char_v  = rb_q && rc_q == '0 && rn_q == dsts_pkg::LAST_BIT;
    assign char_ok = char_v && full[9] && ((^full[8:0]) == cfg.parity_odd);
    assign gap_to  = f_q != dsts_pkg::F_STX && gp_q > cfg.ichar_max;
    assign {hit, bc} = addr_dec(adr_q, cfg.node);
    // check compare, silent discard of others
    assign acc     = char_ok && f_q == dsts_pkg::F_CHK && x_q == full[7:0] && hit;
    assign data_ph = ti_q >= dsts_pkg::TX_HDR && ti_q <= {1'b0, len_q};
    assign tx_load = t_q == dsts_pkg::T_SEND && !tb_q && (!data_ph || fo_valid);
    assign buf_we  = char_ok && f_q == dsts_pkg::F_DATA;
    assign di_tx   = 8'(ti_q - dsts_pkg::TX_HDR);

    // Byte to send
    always_comb begin
        tbyte = fo_data;
        if (ti_q == 9'h000) tbyte = dsts_pkg::STX_BYTE;
        else if (ti_q == 9'h001) tbyte = len_q;
        else if (ti_q == 9'h002) tbyte = adr_q;
        else if (!data_ph) tbyte = tx_x_q;
        else if (req_q.kind == dsts_pkg::TG_PARAM && rsp_fail) begin
            if (di_tx == dsts_pkg::OFS_PID) tbyte = {dsts_pkg::CC_FAIL, fo_data[3:0]};
            else if (di_tx == dsts_pkg::OFS_VAL_LO) tbyte = rsp_fault[15:8];
            else if (di_tx == dsts_pkg::OFS_VAL_LO + 8'h01) tbyte = rsp_fault[7:0];
        end
    end

    // Next state of receiver, parser and transmitter
    always_comb begin
        tk_d = tick ? cfg.baud_div - 16'h0001 : tk_q - 16'h0001;
        rb_d = rb_q; rc_d = rc_q; rn_d = rn_q; rs_d = rs_q;
        gp_d = (f_q == dsts_pkg::F_STX || rb_q) ? '0 : gp_q + 16'(tick);
        f_d = f_q; x_d = x_q; len_d = len_q; adr_d = adr_q; di_d = di_q;
        req_d = req_q; rv_d = 1'b0;
        t_d = t_q; dl_d = dl_q; ti_d = ti_q; tx_x_d = tx_x_q;
        tb_d = tb_q; tc_d = tc_q; tn_d = tn_q; tsh_d = tsh_q;
        if (!rb_q && !line_rx && t_q == dsts_pkg::T_IDLE) begin
            rb_d = 1'b1;
            rc_d = {1'b0, cfg.baud_div[15:1]};
            rn_d = '0;
        end else if (rb_q && rc_q != '0) begin
            rc_d = rc_q - 16'h0001;
        end else if (rb_q) begin
            rc_d = cfg.baud_div - 16'h0001;
            rn_d = rn_q + 4'h1;
            rs_d = full;
            if ((rn_q == '0 && line_rx) || rn_q == dsts_pkg::LAST_BIT) rb_d = 1'b0;
        end
        if (gap_to || (char_v && !char_ok)) begin
            f_d = dsts_pkg::F_STX;
        end else if (char_ok) begin
            x_d = x_q ^ full[7:0];
            unique case (f_q)
                dsts_pkg::F_STX: begin
                    x_d = full[7:0];
                    if (full[7:0] == dsts_pkg::STX_BYTE) f_d = dsts_pkg::F_LEN;
                end
                dsts_pkg::F_LEN: begin
                    len_d = full[7:0];
                    f_d = (full[7:0] == dsts_pkg::LEN_PROC || full[7:0] >= dsts_pkg::LEN_TEXT_MIN)
                        ? dsts_pkg::F_ADR : dsts_pkg::F_STX;
                end
                dsts_pkg::F_ADR: begin
                    adr_d = full[7:0];
                    di_d  = '0;
                    f_d   = dsts_pkg::F_DATA;
                end
                dsts_pkg::F_DATA: begin
                    di_d = di_q + 8'h01;
                    if (di_q == len_q - 8'h03) f_d = dsts_pkg::F_CHK;
                end
                dsts_pkg::F_CHK: f_d = dsts_pkg::F_STX;
                default: f_d = dsts_pkg::F_STX;
            endcase
        end
        if (acc) begin
            rv_d = 1'b1;
            req_d.adr = adr_q;
            req_d.len = len_q;
            req_d.bcast = bc;
            req_d.kind = len_q == dsts_pkg::LEN_PROC ? dsts_pkg::TG_PROC
                       : len_q == dsts_pkg::LEN_PARAM ? dsts_pkg::TG_PARAM : dsts_pkg::TG_TEXT;
            req_d.param_id    = word_at(dsts_pkg::OFS_PID);
            req_d.param_index = word_at(dsts_pkg::OFS_IDX);
            req_d.value_hi    = word_at(dsts_pkg::OFS_VAL_HI);
            req_d.value_lo    = word_at(dsts_pkg::OFS_VAL_LO);
            if (len_q == dsts_pkg::LEN_PROC) begin
                req_d.pcd1 = word_at(dsts_pkg::OFS_PRC_PROC);
                req_d.pcd2 = word_at(dsts_pkg::OFS_PRC_PROC + 8'h02);
            end else begin
                req_d.pcd1 = word_at(dsts_pkg::OFS_PRC_PAR);
                req_d.pcd2 = word_at(dsts_pkg::OFS_PRC_PAR + 8'h02);
            end
        end
        // Response sequencer
        unique case (t_q)
            dsts_pkg::T_IDLE: begin
                if (acc && !bc) begin
                    t_d  = dsts_pkg::T_WAIT;
                    dl_d = '0;
                end
            end
            dsts_pkg::T_WAIT: begin
                if (dl_q >= cfg.resp_dly) begin
                    t_d    = dsts_pkg::T_SEND;
                    ti_d   = '0;
                    tx_x_d = '0;
                end else begin
                    dl_d = dl_q + 16'(tick);
                end
            end
            dsts_pkg::T_SEND: begin
                if (tx_load) begin
                    ti_d   = ti_q + 9'h001;
                    tx_x_d = tx_x_q ^ tbyte;
                    if (ti_q == {1'b0, len_q} + 9'h001) t_d = dsts_pkg::T_END;
                end
            end
            dsts_pkg::T_END: if (!tb_q) t_d = dsts_pkg::T_IDLE;
        endcase
        // Character shifter
        if (tx_load) begin
            tb_d  = 1'b1;
            tc_d  = cfg.baud_div - 16'h0001;
            tn_d  = '0;
            tsh_d = {1'b1, (^tbyte) ^ cfg.parity_odd, tbyte, 1'b0};
        end else if (tb_q && tc_q != '0) begin
            tc_d = tc_q - 16'h0001;
        end else if (tb_q) begin
            tc_d  = cfg.baud_div - 16'h0001;
            tn_d  = tn_q + 4'h1;
            tsh_d = {1'b1, tsh_q[10:1]};
            if (tn_q == dsts_pkg::LAST_BIT) tb_d = 1'b0;
        end
        tx_d = tb_d ? tsh_d[0] : 1'b1;
        oe_d = t_d == dsts_pkg::T_SEND || t_d == dsts_pkg::T_END;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tk_q <= '0; rc_q <= '0; gp_q <= '0; dl_q <= '0; tc_q <= '0;
            rn_q <= '0; tn_q <= '0; rs_q <= '0; tsh_q <= '1;
            rb_q <= 1'b0; tb_q <= 1'b0; tx_q <= 1'b1; oe_q <= 1'b0; rv_q <= 1'b0;
            x_q <= '0; len_q <= '0; adr_q <= '0; di_q <= '0; tx_x_q <= '0; ti_q <= '0;
            f_q <= dsts_pkg::F_STX; t_q <= dsts_pkg::T_IDLE; req_q <= '0;
        end else begin
            tk_q <= tk_d; rc_q <= rc_d; gp_q <= gp_d; dl_q <= dl_d; tc_q <= tc_d;
            rn_q <= rn_d; tn_q <= tn_d; rs_q <= rs_d; tsh_q <= tsh_d;
            rb_q <= rb_d; tb_q <= tb_d; tx_q <= tx_d; oe_q <= oe_d; rv_q <= rv_d;
            x_q <= x_d; len_q <= len_d; adr_q <= adr_d; di_q <= di_d; tx_x_q <= tx_x_d; ti_q <= ti_d;
            f_q <= f_d; t_q <= t_d; req_q <= req_d;
        end
    end

    // Receive data store
    always_ff @(posedge clk) begin
        if (buf_we) rbuf[di_q] <= full[7:0];
    end

    assign line_tx    = tx_q;
    assign line_tx_en = oe_q;
    assign req_valid  = rv_q;
    assign req        = req_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tx_needs_req: assert property (t_q == dsts_pkg::T_IDLE && t_d != dsts_pkg::T_IDLE |-> acc && !bc)
        else $error("answer started without request");
    a_half_duplex: assert property (oe_q |-> !rb_q)
        else $error("receiving while driving line");
    a_char_frame: assert property (tx_load |=> tsh_q[0] == 1'b0 && tsh_q[10] == 1'b1 && tn_q == '0)
        else $error("bad character frame");
    a_tx_parity: assert property (tx_load |=> (^tsh_q[9:1]) == cfg.parity_odd)
        else $error("bad transmit parity");
    a_stx_first: assert property (tx_load && ti_q == 9'h000 |=> tsh_q[8:1] == dsts_pkg::STX_BYTE)
        else $error("first byte not start byte");
    a_addr_echo: assert property (tx_load && ti_q == 9'h002 |=> tsh_q[8:1] == $past(adr_q))
        else $error("address not echoed");
    a_len_echo: assert property (tx_load && ti_q == 9'h001 |=> tsh_q[8:1] == req_q.len)
        else $error("length differs from request");
    a_bcast_quiet: assert property (acc && bc |=> t_q == dsts_pkg::T_IDLE ##1 t_q == dsts_pkg::T_IDLE)
        else $error("broadcast answered");
    a_gap_abort: assert property (gap_to |=> f_q == dsts_pkg::F_STX && !rv_q)
        else $error("telegram kept after gap");
    a_bad_check: assert property (char_ok && f_q == dsts_pkg::F_CHK && x_q != full[7:0] |=> !rv_q)
        else $error("bad check byte accepted");
    a_min_delay: assert property (t_q == dsts_pkg::T_WAIT && t_d == dsts_pkg::T_SEND |-> dl_q >= cfg.resp_dly)
        else $error("answer before minimum delay");
    a_accept_pulse: assert property (acc |=> rv_q ##1 !rv_q || $past(acc))
        else $error("accept not reported");

    c_proc_answered: cover property (acc && len_q == dsts_pkg::LEN_PROC && !bc ##[1:300] oe_q);
    c_param_fail: cover property (tx_load && data_ph && rsp_fail && req_q.kind == dsts_pkg::TG_PARAM);
    c_bcast_seen: cover property (acc && bc);
    c_gap_abort: cover property (gap_to);
endmodule : dsts_slave

// [design/dsts_pkg.sv]
// What this block does
// - Transmit only as answer to a request addressed to this node; never unprompted.
// - Half duplex: drive the line only after a full request, never while receiving.
// - Process telegram 8 bytes, parameter telegram 16 bytes, plus variable text telegram.
// - Character: start bit, eight data bits, parity bit, stop bit; eleven bits.
// - Even parity by default: data bits plus parity bit hold an even count of ones.
// - Telegram order: start byte 02, length, address, data bytes, check byte.
// - Length byte is data count plus two; data is 4 or 12 bytes.
// - Text telegram length byte is ten fixed bytes plus the text bytes.
// - Address bit 7 low: short format, bit 5 broadcast, else node 1..31.
// - Address bit 7 high: bits 6..0 node 1..126, zero means broadcast.
// - Response echoes the received address byte unchanged.
// - Check byte is XOR of all telegram bytes, accumulator cleared per telegram.
// - Response uses the same telegram type and length as the request.
// - Process block: control word, reference in; status word, output frequency out.
// - Parameter block: identifier, index, value high, value low, then two process words.
// - Node address 1..126 and line rate 2400..115200 baud are configurable.
// - Wait at least the programmed minimum delay before answering.
// - Abandon a telegram when the gap between received bytes exceeds the maximum.
// - Identifier word: bits 15..12 command or response code, bits 10..0 parameter number.
// - Failed parameter command answers response code 0111 with fault code in value low.
package dsts_pkg;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          BAUD_MIN      = 2400;
    localparam int          BAUD_MAX      = 115200;
    localparam logic [15:0] DIV_SLOWEST   = 16'(CLK_HZ / BAUD_MIN);
    localparam logic [15:0] DIV_FASTEST   = 16'(CLK_HZ / BAUD_MAX);
    localparam logic [3:0]  LAST_BIT      = 4'hA;
    localparam logic [7:0]  STX_BYTE      = 8'h02;
    localparam logic [7:0]  LEN_PROC      = 8'h06;
    localparam logic [7:0]  LEN_PARAM     = 8'h0E;
    localparam logic [7:0]  LEN_TEXT_MIN  = 8'h0A;
    localparam logic [8:0]  TX_HDR        = 9'h003;
    localparam int          ADR_FMT_BIT   = 7;
    localparam int          ADR_BC_BIT    = 5;
    localparam logic [6:0]  NODE_MIN      = 7'h01;
    localparam logic [6:0]  NODE_MAX      = 7'h7E;
    localparam logic [3:0]  CC_FAIL       = 4'h7;
    localparam logic [7:0]  OFS_PID       = 8'h00;
    localparam logic [7:0]  OFS_IDX       = 8'h02;
    localparam logic [7:0]  OFS_VAL_HI    = 8'h04;
    localparam logic [7:0]  OFS_VAL_LO    = 8'h06;
    localparam logic [7:0]  OFS_PRC_PAR   = 8'h08;
    localparam logic [7:0]  OFS_PRC_PROC  = 8'h00;

    typedef enum logic [1:0] {TG_PROC = 2'b00, TG_PARAM = 2'b01, TG_TEXT = 2'b10} dsts_tg_t;
    typedef enum logic [2:0] {F_STX = 3'b000, F_LEN = 3'b001, F_ADR = 3'b010, F_DATA = 3'b011,
                              F_CHK = 3'b100} dsts_fs_t;
    typedef enum logic [1:0] {T_IDLE = 2'b00, T_WAIT = 2'b01, T_SEND = 2'b10, T_END = 2'b11} dsts_ts_t;

    typedef struct packed {
        logic [6:0]  node;
        logic [15:0] baud_div;
        logic        parity_odd;
        logic [15:0] resp_dly;
        logic [15:0] ichar_max;
    } dsts_cfg_t;

    typedef struct packed {
        dsts_tg_t    kind;
        logic        bcast;
        logic [7:0]  adr;
        logic [7:0]  len;
        logic [15:0] param_id;
        logic [15:0] param_index;
        logic [15:0] value_hi;
        logic [15:0] value_lo;
        logic [15:0] pcd1;
        logic [15:0] pcd2;
    } dsts_req_t;
endpackage : dsts_pkg

// [verification/dsts_master_model.sv]
// Bus master model: sends request characters, decodes answer characters
module dsts_master_model (
    input  wire logic        clk,
    input  wire logic [15:0] baud_div,
    input  wire logic        parity_odd,
    output logic             line_rx,
    input  wire logic        line_tx,
    input  wire logic        line_tx_en
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       busy;
    logic [7:0] rx_byte;
    logic       perr;
    logic [9:0] sh;
    event       got;

    task automatic send(input logic [7:0] b, input logic bad_par);
        logic [10:0] f;
        f    = {1'b1, ^b ^ parity_odd ^ bad_par, b, 1'b0};
        busy = 1'b1;
        for (int i = 0; i < 11; i++) begin
            line_rx = f[i];
            repeat (baud_div) @(posedge clk);
            #1;
        end
        busy = 1'b0;
    endtask : send

    // Biased bus idles high between frames
    initial begin
        line_rx = 1'b1;
        busy    = 1'b0;
    end

    initial begin
        forever begin
            @(posedge clk);
            if (line_tx_en === 1'b1 && line_tx === 1'b0) begin
                repeat (baud_div / 2) @(posedge clk);
                for (int i = 0; i < 10; i++) begin
                    repeat (baud_div) @(posedge clk);
                    sh[i] = line_tx;
                end
                rx_byte = sh[7:0];
                perr    = (^sh[8:0] != parity_odd) || !sh[9];
                -> got;
            end
        end
    end
endmodule : dsts_master_model

// [verification/tb_drive_serial_telegram_slave.sv]
`define CHK(a, b) begin \
    got_v = 64'(a); \
    exp_v = 64'(b); \
    cmp_count++; \
    if (got_v !== exp_v) begin \
        fails++; \
        $display("[ERR] %0t got %0h exp %0h", $time, got_v, exp_v); \
    end \
end

module tb_drive_serial_telegram_slave;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 clk;
    logic                 rst;
    dsts_pkg::dsts_cfg_t  cfg;
    logic                 line_rx;
    logic                 line_tx;
    logic                 line_tx_en;
    logic                 req_valid;
    dsts_pkg::dsts_req_t  req;
    logic [7:0]           rsp_data;
    logic                 rsp_valid;
    logic                 rsp_ready;
    logic                 rsp_fail;
    logic [15:0]          rsp_fault;
    logic [63:0]          got_v;
    logic [63:0]          exp_v;
    logic [50:0]          req_seen;
    logic                 tx_en_q;
    int                   fails = 0;
    int                   cmp_count = 0;
    int                   dly_cnt = 0;
    integer               seed = 32'h2481C90C;
    logic [50:0]          req_q[$];
    logic [7:0]           rsp_q[$];
    logic [63:0]          prm_q[$];

    assign req_seen = {req.kind, req.bcast, req.adr, req.len, req.pcd1, req.pcd2};

    dsts_slave #(.FIFO_DEPTH(8)) DUT (
        .clk       (clk),
        .rst       (rst),
        .cfg       (cfg),
        .line_rx   (line_rx),
        .line_tx   (line_tx),
        .line_tx_en(line_tx_en),
        .req_valid (req_valid),
        .req       (req),
        .rsp_data  (rsp_data),
        .rsp_valid (rsp_valid),
        .rsp_ready (rsp_ready),
        .rsp_fail  (rsp_fail),
        .rsp_fault (rsp_fault)
    );

    dsts_master_model master (
        .clk       (clk),
        .baud_div  (cfg.baud_div),
        .parity_odd(cfg.parity_odd),
        .line_rx   (line_rx),
        .line_tx   (line_tx),
        .line_tx_en(line_tx_en)
    );

    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic summarize;
        $display("TB: %0d compares, %0d errors", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // One answer byte into the FIFO, held until taken
    task automatic push(input logic [7:0] b);
        int n;
        n         = 0;
        rsp_data  = b;
        rsp_valid = 1'b1;
        while (rsp_ready !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 5000) begin
            fails++;
            summarize();
        end
        @(posedge clk);
        #1;
    endtask : push

    // Telegram with notes; bad: 1 check, 2 parity, 3 gap, 4 slow, 5 drop
    task automatic tg(input logic [6:0] node, input logic [7:0] adr, input logic [7:0] len,
                      input int bad, input logic fail, input logic odd);
        logic [7:0]         d[16];
        logic [7:0]         r[16];
        logic [7:0]         x;
        logic [7:0]         y;
        logic [7:0]         e;
        logic               bc;
        logic               ok;
        dsts_pkg::dsts_tg_t kd;
        int                 k;
        int                 o;
        int                 n;
        cfg.node       = node;
        cfg.parity_odd = odd;
        rsp_fail       = fail;
        rsp_fault      = 16'($random(seed));
        bc = adr[7] ? (adr[6:0] == 7'h00) : adr[5];
        ok = (bad == 0 || bad == 4);
        k  = int'(len) - 2;
        o  = (len == 8'h06) ? 0 : 8;
        kd = (len == 8'h06) ? dsts_pkg::TG_PROC : (len == 8'h0E) ? dsts_pkg::TG_PARAM : dsts_pkg::TG_TEXT;
        x  = 8'h02 ^ len ^ adr;
        y  = x;
        if (ok && !bc) begin
            rsp_q.push_back(8'h02);
            rsp_q.push_back(len);
            rsp_q.push_back(adr);
        end
        for (int i = 0; i < k; i++) begin
            d[i] = 8'($random(seed));
            r[i] = 8'($random(seed));
            x ^= d[i];
            e = r[i];
            if (fail && kd == dsts_pkg::TG_PARAM) begin
                e = (i == 0) ? {4'h7, r[0][3:0]} : (i == 6) ? rsp_fault[15:8] : (i == 7) ? rsp_fault[7:0] : e;
            end
            y ^= e;
            if (ok && !bc) rsp_q.push_back(e);
        end
        if (ok && !bc) rsp_q.push_back(y);
        if (ok) req_q.push_back({kd, bc, adr, len, d[o], d[o + 1], d[o + 2], d[o + 3]});
        if (ok && kd != dsts_pkg::TG_PROC) prm_q.push_back({d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]});
        fork
            begin
                master.send(8'h02, 1'b0);
                master.send(len, 1'b0);
                master.send(adr, bad == 2);
                for (int i = 0; i < k && !(bad == 3 && i == 2); i++) begin
                    if (bad == 4) begin
                        repeat (12) @(posedge clk);
                        #1;
                    end
                    master.send(d[i], 1'b0);
                end
                if (bad != 3) master.send(bad == 1 ? x ^ 8'h01 : x, 1'b0);
            end
            begin
                for (int i = 0; i < k && ok && !bc; i++) push(r[i]);
                rsp_valid = 1'b0;
            end
        join
        n = 0;
        while ((req_q.size() != 0 || rsp_q.size() != 0 || line_tx_en !== 1'b0) && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 4000) begin
            fails++;
            summarize();
        end
        repeat (60) @(posedge clk);
        #1;
    endtask : tg

    always @(posedge clk) begin
        if (req_valid === 1'b1) begin
            `CHK(req_q.size() != 0, 1'b1)
            if (req_q.size() != 0) `CHK(req_seen, req_q.pop_front())
            if (req.kind != dsts_pkg::TG_PROC && prm_q.size() != 0)
                `CHK({req.param_id, req.param_index, req.value_hi, req.value_lo}, prm_q.pop_front())
        end
    end

    always @(master.got) begin
        `CHK(rsp_q.size() != 0, 1'b1)
        if (rsp_q.size() != 0) `CHK({master.perr, master.rx_byte}, {1'b0, rsp_q.pop_front()})
    end

    always @(posedge clk) begin
        if (master.busy === 1'b1) `CHK(line_tx_en, 1'b0)
        if (req_valid === 1'b1) dly_cnt = 0;
        else dly_cnt++;
        if (line_tx_en === 1'b1 && tx_en_q !== 1'b1) `CHK(dly_cnt >= (cfg.resp_dly - 1) * cfg.baud_div, 1'b1)
        tx_en_q = line_tx_en;
    end

    // Reset, then the telegram sequence
    initial begin
        rst            = 1'b1;
        cfg.node       = 7'h05;
        cfg.baud_div   = 16'h0004;
        cfg.parity_odd = 1'b0;
        cfg.resp_dly   = 16'h0003;
        cfg.ichar_max  = 16'h0004;
        rsp_data       = 8'h00;
        rsp_valid      = 1'b0;
        rsp_fail       = 1'b0;
        rsp_fault      = 16'h0000;
        repeat (3) @(posedge clk);
        #1;
        `CHK({line_tx_en, line_tx, req_valid, rsp_ready}, 4'h4)
        rst = 1'b0;
        @(posedge clk);
        #1;
        `CHK(rsp_ready, 1'b1)
        tg(7'h05, 8'h85, 8'h06, 0, 1'b0, 1'b0);
        tg(7'h05, 8'h05, 8'h0E, 0, 1'b1, 1'b0);
        tg(7'h05, 8'h45, 8'h10, 4, 1'b0, 1'b0);
        tg(7'h05, 8'h25, 8'h06, 0, 1'b0, 1'b0);
        tg(7'h05, 8'h80, 8'h0E, 0, 1'b0, 1'b0);
        tg(7'h05, 8'h86, 8'h06, 5, 1'b0, 1'b0);
        tg(7'h05, 8'h85, 8'h06, 1, 1'b0, 1'b0);
        tg(7'h05, 8'h85, 8'h06, 2, 1'b0, 1'b0);
        tg(7'h05, 8'h85, 8'h06, 3, 1'b0, 1'b0);
        tg(7'h05, 8'h83, 8'h07, 5, 1'b0, 1'b0);
        tg(7'h7E, 8'hFE, 8'h06, 0, 1'b0, 1'b1);
        cfg.baud_div = 16'h0007;
        tg(7'h1F, 8'h1F, 8'h0E, 0, 1'b0, 1'b0);
        `CHK(req_q.size() + rsp_q.size() + prm_q.size(), 0)
        summarize();
    end
endmodule : tb_drive_serial_telegram_slave
